// >>> hw/fns_regs.svh
`ifndef FNS_REGS_SVH
`define FNS_REGS_SVH

// byte offsets of the register words
`define FNS_OFS_B1_W0 8'h00
`define FNS_OFS_B1_W1 8'h04
`define FNS_OFS_B1_W2 8'h08
`define FNS_OFS_B1_W3 8'h0C
`define FNS_OFS_B2_W0 8'h10
`define FNS_OFS_B2_W1 8'h14
`define FNS_OFS_B2_W2 8'h18
`define FNS_OFS_B2_W3 8'h1C
`define FNS_OFS_CONFIG_WORD_ONE 8'h20
`define FNS_OFS_CONFIG_WORD_FIVE 8'h24
`define FNS_OFS_RB1 8'h28

// bank word zero fields
`define FNS_W0_OSC_SEL 1:0
`define FNS_W0_SEARCH_EN 2
`define FNS_W0_OUT_DIV 4:3
`define FNS_W0_DEF_BAND 11:5
`define FNS_W0_PUMP_SCALE 16:12
`define FNS_W0_CORE_CUR 20:17
// bank words one to three
`define FNS_W1_INT_DIV 9:0
`define FNS_W2_FRAC_UPPER 15:0
`define FNS_W3_FRAC_LOWER 7:0
// config word one
`define FNS_C1_FULL_DUPLEX 0
`define FNS_C1_PUMP_LOW 1
`define FNS_C1_AUTO_BW 2
`define FNS_C1_FREQ_LOCK_FACTOR 4:3
`define FNS_C1_REF_BYPASS 12
`define FNS_C1_REF_DIV 15:13
// config word five
`define FNS_C5_BUF1 3:0
`define FNS_C5_BUF2 7:4
// read-back word one
`define FNS_RB_BAND 6:0
`define FNS_RB_BUSY 7
`define FNS_RB_FAIL 8
`define FNS_RB_BANK 9

// reset values
`define FNS_RST_OSC_SEL 2'h1
`define FNS_RST_SEARCH_EN 1'h1
`define FNS_RST_OUT_DIV 2'h0
`define FNS_RST_DEF_BAND 7'h40
`define FNS_RST_PUMP_SCALE 5'h1F
`define FNS_RST_CORE_CUR 4'h8
`define FNS_RST_INT_DIV 10'h04B
`define FNS_RST_FRAC 24'h000000
`define FNS_RST_FREQ_LOCK_FACTOR 2'h1
`define FNS_RST_REF_BYPASS 1'h1
`define FNS_RST_REF_DIV 3'h2
`define FNS_RST_BUF 4'h8

// band search figures
`define FNS_BAND_MAX 7'h7F
`define FNS_BAND_MIN 7'h00
`define FNS_BAND_START 7'h40
`define FNS_BAND_BITS 3'h7
`define FNS_SEARCH_CYCLES 1500
`define FNS_STEP_CYCLES (`FNS_SEARCH_CYCLES / 7)

// output divide codes and ratios
`define FNS_DIV_BY1 2'h0
`define FNS_DIV_BY2 2'h1
`define FNS_RATIO_1 3'h1
`define FNS_RATIO_2 3'h2
`define FNS_RATIO_4 3'h4

// charge pump base currents in microamps and the full scale divisor
`define FNS_PUMP_BASE_HI_UA 8'h78
`define FNS_PUMP_BASE_LO_UA 8'h1E
`define FNS_PUMP_FULL_SCALE 13'h001F

// reference divider
`define FNS_REF_MIN_CODE 3'h2

`endif

// >>> hw/fns_pkg.sv
package fns_pkg;

	typedef enum logic [1:0] {
		FNS_IDLE = 2'b00,
		FNS_MEASURE = 2'b01,
		FNS_DONE = 2'b10
	} fns_search_state_e;

	typedef struct packed {
		logic [1:0] osc_sel;
		logic search_en;
		logic [1:0] out_div;
		logic [6:0] default_band;
		logic [4:0] pump_scale;
		logic [3:0] core_current;
		logic [9:0] int_div;
		logic [23:0] frac;
	} fns_bank_s;

endpackage

// >>> hw/fns_core_if.sv
`timescale 1ns/1ps

interface fns_core_if;
	logic ref_bypass;
	logic [2:0] ref_div;
	logic pd_tick;
	logic search_start;
	logic osc_fast;
	logic [6:0] band;
	logic busy;
	logic done;

	modport refdiv (
		input ref_bypass,
		input ref_div,
		output pd_tick
	);

	modport search (
		input pd_tick,
		input search_start,
		input osc_fast,
		output band,
		output busy,
		output done
	);

	modport ctrl (
		output ref_bypass,
		output ref_div,
		input pd_tick,
		output search_start,
		output osc_fast,
		input band,
		input busy,
		input done
	);
endinterface // fns_core_if

// >>> hw/fns_ref_div.sv
`timescale 1ns/1ps
`include "fns_regs.svh"

module fns_ref_div (
	input wire logic pclk,
	input wire logic presetn,
	fns_core_if.refdiv core
);

	logic [2:0] count_q;
	logic [2:0] ratio;

	// bypass forces one, else codes two to seven divide by themselves
	always_comb begin
		if (core.ref_bypass || core.ref_div < `FNS_REF_MIN_CODE) begin
			ratio = `FNS_RATIO_1;
		end else begin
			ratio = core.ref_div;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 3'h0;
		end else if (count_q >= ratio - 3'h1) begin
			count_q <= 3'h0;
		end else begin
			count_q <= count_q + 3'h1;
		end
	end

	// one phase detector tick per divided reference period
	assign core.pd_tick = (count_q >= ratio - 3'h1);

endmodule // fns_ref_div

// >>> hw/fns_band_search.sv
`timescale 1ns/1ps
`include "fns_regs.svh"

module fns_band_search (
	input wire logic pclk,
	input wire logic presetn,
	fns_core_if.search core
);

	fns_pkg::fns_search_state_e state_q;
	logic [6:0] band_q;
	logic [2:0] bit_q;
	logic [7:0] dwell_q;
	logic step_end;

	assign step_end = core.pd_tick && (dwell_q == 8'(`FNS_STEP_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= fns_pkg::FNS_IDLE;
		end else begin
			case (state_q)
				fns_pkg::FNS_IDLE: begin
					if (core.search_start) begin
						state_q <= fns_pkg::FNS_MEASURE;
					end
				end
				fns_pkg::FNS_MEASURE: begin
					if (step_end && bit_q == 3'h0) begin
						state_q <= fns_pkg::FNS_DONE;
					end
				end
				default: begin
					state_q <= core.search_start ? fns_pkg::FNS_MEASURE : fns_pkg::FNS_DONE;
				end
			endcase
		end
	end

	// dwell counter in phase detector ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dwell_q <= 8'h00;
		end else if (core.search_start || step_end) begin
			dwell_q <= 8'h00;
		end else if (state_q == fns_pkg::FNS_MEASURE && core.pd_tick) begin
			dwell_q <= dwell_q + 8'h01;
		end
	end

	// capacitance steps added from the largest; kept while oscillator still too fast
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			band_q <= `FNS_BAND_MIN;
			bit_q <= 3'h0;
		end else if (core.search_start) begin
			band_q <= `FNS_BAND_START;
			bit_q <= `FNS_BAND_BITS - 3'h1;
		end else if (state_q == fns_pkg::FNS_MEASURE && step_end) begin
			if (!core.osc_fast) begin
				band_q[bit_q] <= 1'b0;
			end
			if (bit_q != 3'h0) begin
				band_q[bit_q - 3'h1] <= 1'b1;
				bit_q <= bit_q - 3'h1;
			end
		end
	end

	assign core.band = band_q;
	assign core.busy = (state_q == fns_pkg::FNS_MEASURE);
	assign core.done = (state_q == fns_pkg::FNS_DONE);

endmodule // fns_band_search

// >>> hw/fns_synth_ctrl.sv
// Behaviour
// - pick one of 128 bands automatically
// - search on chip enable rise, then lock
// - add capacitance steps until near target
// - report band; 0 or 127 means failure
// - search lasts about 1500 detector cycles
// - stored band used when search disabled
// - per bank output divide one, two, four
// - route signal to mixers by mode, duplex
// - bank follows selected mixer via mode pin
// - mode low bank one; duplex feeds both
// - per bank core current while bank active
// - reference divide 1 to 7, bypass forces one
// - field 15:13 codes 2 to 7 set division
// - oscillator settles at N times ref over R
// - base pump current 120uA, 30uA when low
// - pump current base times scale over 31
// - auto bandwidth sets pump; off at reset
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "fns_regs.svh"

module fns_synth_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chip_enable_pin,
	input wire logic mode_pin,
	input wire logic osc_above_target,
	input wire logic [4:0] gain_pump_scale,
	output logic [1:0] osc_select,
	output logic [6:0] osc_band,
	output logic [3:0] osc_core_current,
	output logic [2:0] lo_divide_ratio,
	output logic mixer1_lo_enable,
	output logic mixer2_lo_enable,
	output logic [3:0] buffer_one_current,
	output logic [3:0] buffer_two_current,
	output logic [9:0] feedback_integer,
	output logic [23:0] feedback_fraction,
	output logic [7:0] pump_current_ua,
	output logic [1:0] freq_lock_factor,
	output logic loop_lock_enable,
	output logic pd_tick
);

	////////////////////////////////////////////////////////////////////////////
	// registers

	fns_pkg::fns_bank_s bank1_q;
	fns_pkg::fns_bank_s bank2_q;
	logic full_duplex_select_q;
	logic pump_low_current_select_q;
	logic auto_bw_enable_q;
	logic [1:0] freq_lock_factor_q;
	logic ref_divider_bypass_q;
	logic [2:0] ref_divide_q;
	logic [3:0] buffer_one_current_q;
	logic [3:0] buffer_two_current_q;
	logic enable_prev_q;
	logic search_owned_q;

	fns_pkg::fns_bank_s active;
	logic bank_two_active;
	logic wr_en;
	logic setup;
	logic mapped;
	logic [31:0] rd_word;
	logic [6:0] band_now;
	logic [4:0] scale_now;
	logic search_fail;

	fns_core_if core ();

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic fns_pkg::fns_bank_s bank_write(input fns_pkg::fns_bank_s b, input logic [1:0] word,
		input logic [31:0] d);
		fns_pkg::fns_bank_s r;
		r = b;
		case (word)
			2'h0: begin
				r.osc_sel = d[`FNS_W0_OSC_SEL];
				r.search_en = d[`FNS_W0_SEARCH_EN];
				r.out_div = d[`FNS_W0_OUT_DIV];
				r.default_band = d[`FNS_W0_DEF_BAND];
				r.pump_scale = d[`FNS_W0_PUMP_SCALE];
				r.core_current = d[`FNS_W0_CORE_CUR];
			end
			2'h1: r.int_div = d[`FNS_W1_INT_DIV];
			2'h2: r.frac[23:8] = d[`FNS_W2_FRAC_UPPER];
			default: r.frac[7:0] = d[`FNS_W3_FRAC_LOWER];
		endcase
		return r;
	endfunction

	function automatic logic [31:0] bank_read(input fns_pkg::fns_bank_s b, input logic [1:0] word);
		logic [31:0] r;
		r = 32'h00000000;
		case (word)
			2'h0: begin
				r[`FNS_W0_OSC_SEL] = b.osc_sel;
				r[`FNS_W0_SEARCH_EN] = b.search_en;
				r[`FNS_W0_OUT_DIV] = b.out_div;
				r[`FNS_W0_DEF_BAND] = b.default_band;
				r[`FNS_W0_PUMP_SCALE] = b.pump_scale;
				r[`FNS_W0_CORE_CUR] = b.core_current;
			end
			2'h1: r[`FNS_W1_INT_DIV] = b.int_div;
			2'h2: r[`FNS_W2_FRAC_UPPER] = b.frac[23:8];
			default: r[`FNS_W3_FRAC_LOWER] = b.frac[7:0];
		endcase
		return r;
	endfunction

	function automatic fns_pkg::fns_bank_s bank_reset();
		fns_pkg::fns_bank_s r;
		r.osc_sel = `FNS_RST_OSC_SEL;
		r.search_en = `FNS_RST_SEARCH_EN;
		r.out_div = `FNS_RST_OUT_DIV;
		r.default_band = `FNS_RST_DEF_BAND;
		r.pump_scale = `FNS_RST_PUMP_SCALE;
		r.core_current = `FNS_RST_CORE_CUR;
		r.int_div = `FNS_RST_INT_DIV;
		r.frac = `FNS_RST_FRAC;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && (paddr[1:0] == 2'h0);
	assign pready = 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank1_q <= bank_reset();
			bank2_q <= bank_reset();
		end else if (wr_en && paddr < `FNS_OFS_B2_W0) begin
			bank1_q <= bank_write(bank1_q, paddr[3:2], pwdata);
		end else if (wr_en && paddr < `FNS_OFS_CONFIG_WORD_ONE) begin
			bank2_q <= bank_write(bank2_q, paddr[3:2], pwdata);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_duplex_select_q <= 1'b0;
			pump_low_current_select_q <= 1'b0;
			auto_bw_enable_q <= 1'b0;
			freq_lock_factor_q <= `FNS_RST_FREQ_LOCK_FACTOR;
			ref_divider_bypass_q <= `FNS_RST_REF_BYPASS;
			ref_divide_q <= `FNS_RST_REF_DIV;
		end else if (wr_en && paddr == `FNS_OFS_CONFIG_WORD_ONE) begin
			full_duplex_select_q <= pwdata[`FNS_C1_FULL_DUPLEX];
			pump_low_current_select_q <= pwdata[`FNS_C1_PUMP_LOW];
			auto_bw_enable_q <= pwdata[`FNS_C1_AUTO_BW];
			freq_lock_factor_q <= pwdata[`FNS_C1_FREQ_LOCK_FACTOR];
			ref_divider_bypass_q <= pwdata[`FNS_C1_REF_BYPASS];
			ref_divide_q <= pwdata[`FNS_C1_REF_DIV];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_one_current_q <= `FNS_RST_BUF;
			buffer_two_current_q <= `FNS_RST_BUF;
		end else if (wr_en && paddr == `FNS_OFS_CONFIG_WORD_FIVE) begin
			buffer_one_current_q <= pwdata[`FNS_C5_BUF1];
			buffer_two_current_q <= pwdata[`FNS_C5_BUF2];
		end
	end

	// read data and error captured in the setup cycle, valid in the access cycle
	always_comb begin
		mapped = 1'b1;
		rd_word = 32'h00000000;
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (paddr < `FNS_OFS_B2_W0) begin
			rd_word = bank_read(bank1_q, paddr[3:2]);
		end else if (paddr < `FNS_OFS_CONFIG_WORD_ONE) begin
			rd_word = bank_read(bank2_q, paddr[3:2]);
		end else if (paddr == `FNS_OFS_CONFIG_WORD_ONE) begin
			rd_word[`FNS_C1_FULL_DUPLEX] = full_duplex_select_q;
			rd_word[`FNS_C1_PUMP_LOW] = pump_low_current_select_q;
			rd_word[`FNS_C1_AUTO_BW] = auto_bw_enable_q;
			rd_word[`FNS_C1_FREQ_LOCK_FACTOR] = freq_lock_factor_q;
			rd_word[`FNS_C1_REF_BYPASS] = ref_divider_bypass_q;
			rd_word[`FNS_C1_REF_DIV] = ref_divide_q;
		end else if (paddr == `FNS_OFS_CONFIG_WORD_FIVE) begin
			rd_word[`FNS_C5_BUF1] = buffer_one_current_q;
			rd_word[`FNS_C5_BUF2] = buffer_two_current_q;
		end else if (paddr == `FNS_OFS_RB1) begin
			rd_word[`FNS_RB_BAND] = core.band;
			rd_word[`FNS_RB_BUSY] = core.busy;
			rd_word[`FNS_RB_FAIL] = search_fail;
			rd_word[`FNS_RB_BANK] = bank_two_active;
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : rd_word;
			pslverr <= !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bank selection and band search control

	assign bank_two_active = mode_pin;
	assign active = bank_two_active ? bank2_q : bank1_q;
	assign search_fail = (core.band == `FNS_BAND_MAX) || (core.band == `FNS_BAND_MIN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_prev_q <= 1'b0;
		end else begin
			enable_prev_q <= chip_enable_pin;
		end
	end

	// search starts on each enable rise unless the bank holds a stored band
	assign core.search_start = chip_enable_pin && !enable_prev_q && active.search_en;
	assign core.osc_fast = osc_above_target;
	assign core.ref_bypass = ref_divider_bypass_q;
	assign core.ref_div = ref_divide_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			search_owned_q <= 1'b0;
		end else if (core.search_start) begin
			search_owned_q <= 1'b1;
		end else if (chip_enable_pin && !enable_prev_q) begin
			search_owned_q <= 1'b0;
		end
	end

	assign band_now = (active.search_en && search_owned_q) ? core.band : active.default_band;
	assign scale_now = auto_bw_enable_q ? gain_pump_scale : active.pump_scale;

	fns_ref_div u_ref_div (
		.pclk(pclk),
		.presetn(presetn),
		.core(core)
	);

	fns_band_search u_band_search (
		.pclk(pclk),
		.presetn(presetn),
		.core(core)
	);

	////////////////////////////////////////////////////////////////////////////
	// registered analog controls

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_select <= `FNS_RST_OSC_SEL;
			osc_band <= `FNS_RST_DEF_BAND;
			osc_core_current <= `FNS_RST_CORE_CUR;
			feedback_integer <= `FNS_RST_INT_DIV;
			feedback_fraction <= `FNS_RST_FRAC;
			loop_lock_enable <= 1'b0;
		end else begin
			osc_select <= active.osc_sel;
			osc_band <= band_now;
			osc_core_current <= active.core_current;
			feedback_integer <= active.int_div;
			feedback_fraction <= active.frac;
			loop_lock_enable <= chip_enable_pin && !core.busy && !core.search_start;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_divide_ratio <= `FNS_RATIO_1;
		end else if (active.out_div == `FNS_DIV_BY1) begin
			lo_divide_ratio <= `FNS_RATIO_1;
		end else if (active.out_div == `FNS_DIV_BY2) begin
			lo_divide_ratio <= `FNS_RATIO_2;
		end else begin
			lo_divide_ratio <= `FNS_RATIO_4;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mixer1_lo_enable <= 1'b0;
			mixer2_lo_enable <= 1'b0;
		end else begin
			mixer1_lo_enable <= full_duplex_select_q || !mode_pin;
			mixer2_lo_enable <= full_duplex_select_q || mode_pin;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pump_current_ua <= `FNS_PUMP_BASE_HI_UA;
		end else if (pump_low_current_select_q) begin
			pump_current_ua <= 8'((13'(`FNS_PUMP_BASE_LO_UA) * 13'(scale_now)) / `FNS_PUMP_FULL_SCALE);
		end else begin
			pump_current_ua <= 8'((13'(`FNS_PUMP_BASE_HI_UA) * 13'(scale_now)) / `FNS_PUMP_FULL_SCALE);
		end
	end

	assign buffer_one_current = buffer_one_current_q;
	assign buffer_two_current = buffer_two_current_q;
	assign freq_lock_factor = freq_lock_factor_q;
	assign pd_tick = core.pd_tick;

endmodule // fns_synth_ctrl

// >>> tb/fns_synth_ctrl_properties.sv
`timescale 1ns/1ps

module fns_props_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic chip_enable_pin,
	input wire logic mode_pin,
	input wire logic [2:0] lo_divide_ratio,
	input wire logic mixer1_lo_enable,
	input wire logic mixer2_lo_enable,
	input wire logic [7:0] pump_current_ua,
	input wire logic [9:0] feedback_integer,
	input wire logic loop_lock_enable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// cycles spent with the enable high and the loop not yet released
	logic [13:0] cnt_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 14'h0000;
		end else if (chip_enable_pin && !loop_lock_enable && cnt_q != 14'h3FFF) begin
			cnt_q <= cnt_q + 14'h0001;
		end else if (loop_lock_enable || !chip_enable_pin) begin
			cnt_q <= 14'h0000;
		end
	end

	a_ratio_legal: assert property (lo_divide_ratio inside {3'h1, 3'h2, 3'h4})
		else $error("lo divide ratio outside one, two, four");
	a_mixer_one: assert property (!mode_pin |=> mixer1_lo_enable)
		else $error("mixer one not fed with mode low");
	a_mixer_two: assert property (mode_pin |=> mixer2_lo_enable)
		else $error("mixer two not fed with mode high");
	a_pump_ceiling: assert property (pump_current_ua <= 8'h78)
		else $error("pump current above base");
	a_lock_enable: assert property (!chip_enable_pin |=> !loop_lock_enable)
		else $error("loop released with enable low");
	a_search_length: assert property ($rose(loop_lock_enable) |->
		(cnt_q < 14'h0004 || (cnt_q >= 14'h05DA && cnt_q <= 14'h2AF8)))
		else $error("band search length wrong");
	a_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access without error");
	a_good_addr: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access flagged");
	a_divider_hold: assert property (!psel && !$past(psel) && $stable(mode_pin) |=> $stable(feedback_integer))
		else $error("feedback integer moved without cause");
endmodule // fns_props_chk

bind fns_synth_ctrl fns_props_chk u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pslverr(pslverr), .chip_enable_pin(chip_enable_pin), .mode_pin(mode_pin),
	.lo_divide_ratio(lo_divide_ratio), .mixer1_lo_enable(mixer1_lo_enable), .mixer2_lo_enable(mixer2_lo_enable),
	.pump_current_ua(pump_current_ua), .feedback_integer(feedback_integer), .loop_lock_enable(loop_lock_enable));

// >>> tb/fns_osc_model.sv
`timescale 1ns/1ps

module fns_osc_model (
	input wire logic [6:0] osc_band,
	input wire logic [7:0] target_band,
	output logic osc_above_target
);
	// fewer capacitance steps leave the oscillator faster than target
	assign osc_above_target = ({1'b0, osc_band} < target_band);
endmodule // fns_osc_model

// >>> tb/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, osc_above_target, mixer1_lo_enable, mixer2_lo_enable, loop_lock_enable, pd_tick;
	logic chip_enable_pin = 1'b0, mode_pin = 1'b0;
	logic [4:0] gain_pump_scale = 5'h07;
	logic [7:0] target_band = 8'h50, pump_current_ua;
	logic [1:0] osc_select, freq_lock_factor;
	logic [6:0] osc_band;
	logic [3:0] osc_core_current, buffer_one_current, buffer_two_current;
	logic [2:0] lo_divide_ratio;
	logic [9:0] feedback_integer;
	logic [23:0] feedback_fraction;
	int fail_count = 0, n_checks = 0;

	always #2.5 pclk = ~pclk;

	fns_synth_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_enable_pin(chip_enable_pin), .mode_pin(mode_pin), .osc_above_target(osc_above_target),
		.gain_pump_scale(gain_pump_scale), .osc_select(osc_select), .osc_band(osc_band),
		.osc_core_current(osc_core_current), .lo_divide_ratio(lo_divide_ratio),
		.mixer1_lo_enable(mixer1_lo_enable), .mixer2_lo_enable(mixer2_lo_enable),
		.buffer_one_current(buffer_one_current), .buffer_two_current(buffer_two_current),
		.feedback_integer(feedback_integer), .feedback_fraction(feedback_fraction),
		.pump_current_ua(pump_current_ua), .freq_lock_factor(freq_lock_factor),
		.loop_lock_enable(loop_lock_enable), .pd_tick(pd_tick));

	fns_osc_model u_osc (.osc_band(osc_band), .target_band(target_band), .osc_above_target(osc_above_target));

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk({q, e}, {x, xe});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h00, 32'h0011F805, 1'b0);
		rd(8'h20, 32'h00005008, 1'b0);
		rd(8'h24, 32'h00000088, 1'b0);
		chk({osc_select, osc_core_current, lo_divide_ratio, mixer1_lo_enable, mixer2_lo_enable},
			{2'h1, 4'h8, 3'h1, 1'b1, 1'b0});
		chk({pump_current_ua, feedback_integer, freq_lock_factor}, {8'h78, 10'h04B, 2'h1});
	endtask

	task automatic t_bus();
		rd(8'h2C, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
		apb(1'b1, 8'h01, 32'h0);
		chk(e, 1'b1);
		rd(8'h00, 32'h0011F805, 1'b0);
		apb(1'b1, 8'h2C, 32'hFFFF);
		chk(e, 1'b1);
		apb(1'b1, 8'h28, 32'hFFFF);
		chk(e, 1'b0);
	endtask

	task automatic t_search(input logic [7:0] tgt, input logic [6:0] band);
		int n;
		n = 0;
		target_band <= tgt;
		chip_enable_pin <= 1'b0;
		cyc(2);
		chip_enable_pin <= 1'b1;
		cyc(2);
		do begin
			apb(1'b0, 8'h28, 32'h0);
			n++;
		end while (q[7] !== 1'b0 && n < 1000);
		chk(q[9:0], {1'b0, (band == 7'h00 || band == 7'h7F), 1'b0, band});
		chk((3 * n + 2 >= 1490) && (3 * n + 2 <= 1515), 1'b1);
		cyc(2);
		chk({osc_band, loop_lock_enable}, {band, 1'b1});
	endtask

	task automatic t_route();
		logic md, dp;
		wr_cfg(8'h00, 32'h0011F469);
		wr_cfg(8'h10, 32'h0006F239);
		chip_enable_pin <= 1'b0;
		cyc(2);
		chip_enable_pin <= 1'b1;
		cyc(3);
		chk({osc_band, loop_lock_enable, lo_divide_ratio}, {7'h23, 1'b1, 3'h2});
		for (int i = 0; i < 4; i++) begin
			md = i[0];
			dp = i[1];
			wr_cfg(8'h20, 32'h00005008 | {31'h0, dp});
			mode_pin <= md;
			cyc(3);
			chk({mixer1_lo_enable, mixer2_lo_enable, osc_band},
				{dp | !md, dp | md, md ? 7'h11 : 7'h23});
			chk({lo_divide_ratio, osc_core_current, pump_current_ua},
				{md ? 3'h4 : 3'h2, md ? 4'h3 : 4'h8, md ? 8'h3A : 8'h78});
		end
		wr_cfg(8'h20, 32'h0000500A);
		cyc(3);
		chk(pump_current_ua, 8'h0E);
		wr_cfg(8'h20, 32'h0000500C);
		cyc(3);
		chk(pump_current_ua, 8'h1B);
		mode_pin <= 1'b0;
	endtask

	task automatic wr_cfg(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic t_frac();
		wr_cfg(8'h04, 32'h0000004B);
		wr_cfg(8'h08, 32'h00004036);
		wr_cfg(8'h0C, 32'h000000CC);
		wr_cfg(8'h24, 32'h000000CC);
		wr_cfg(8'h20, 32'h00005000);
		cyc(3);
		chk({feedback_integer, feedback_fraction}, {10'h04B, 24'h4036CC});
		chk({buffer_one_current, buffer_two_current, freq_lock_factor}, {4'hC, 4'hC, 2'h0});
	endtask

	task automatic t_refdiv(input logic [31:0] cfg, input int per);
		int n;
		n = 0;
		wr_cfg(8'h20, cfg);
		cyc(10);
		repeat (42) begin
			@(negedge pclk);
			if (pd_tick === 1'b1) n++;
		end
		chk(n, 42 / per);
	endtask

	initial begin
		cyc(3);
		presetn <= 1'b1;
		t_reset();
		t_bus();
		t_search(8'h50, 7'h4F);
		t_search(8'h00, 7'h00);
		t_search(8'h80, 7'h7F);
		t_route();
		t_frac();
		t_refdiv(32'h00006000, 3);
		t_refdiv(32'h00004000, 2);
		t_refdiv(32'h0000E000, 7);
		t_refdiv(32'h0000F000, 1);
		close_out();
	end

	initial begin
		#100000;
		fail_count++;
		close_out();
	end
endmodule // testbench
